// ### common/hsm_pkg.sv
// shared constants and types for the hall sensor mode and serial access block
package hsm_pkg;
   // clock and timing
   localparam int CLK_MHZ         = 100;
   localparam int CNT_W           = 24;
   localparam int ADDR_CAPTURE_US = 260;
   localparam int ADDR_CAPTURE_CYC = ADDR_CAPTURE_US * CLK_MHZ;
   localparam int ULP_PERIOD_US   = 100000;
   localparam int ULP_PERIOD_CYC  = ULP_PERIOD_US * CLK_MHZ;
   localparam int LOWP_PERIOD_US  = 12000;
   localparam int LOWP_PERIOD_CYC = LOWP_PERIOD_US * CLK_MHZ;
   localparam int INT_PULSE_NS    = 1000;
   localparam int INT_PULSE_CYC   = (INT_PULSE_NS * CLK_MHZ + 999) / 1000;

   // register indices
   localparam logic [3:0] WREG_CFG1     = 4'h1;
   localparam logic [3:0] WREG_CFG3     = 4'h3;
   localparam logic [3:0] WAKE_FIRST    = 4'h7;
   localparam logic [3:0] WAKE_LAST     = 4'hc;
   localparam logic [3:0] RD_LAST_RO    = 4'h6;
   localparam logic [3:0] RD_FLAG_IDX   = 4'h6;
   localparam logic [7:0] WREG_RESET    = 8'h00;

   // field positions
   localparam int CFG1_LOW_BIT     = 0;
   localparam int CFG1_FAST_BIT    = 1;
   localparam int CFG1_INT_BIT     = 2;
   localparam int CFG1_ASEL_LSB    = 5;
   localparam int CFG3_PERIOD_BIT  = 6;
   localparam int CFG3_CHECK_BIT   = 7;
   localparam int FLAG_IDLE_BIT    = 0;
   localparam int FLAG_CONSIST_BIT = 1;

   // 7-bit slave addresses per select value
   localparam logic [6:0] ADDR_SEL_11 = 7'h4a;
   localparam logic [6:0] ADDR_SEL_10 = 7'h4e;
   localparam logic [6:0] ADDR_SEL_01 = 7'h5a;
   localparam logic [6:0] ADDR_SEL_00 = 7'h5e;

   typedef enum logic [2:0] {
      MODE_POWER_DOWN,
      MODE_CONTINUOUS,
      MODE_LOW_POWER,
      MODE_ULTRA_LOW_POWER,
      MODE_MASTER_TRIGGERED
   } hsm_mode_e;

   typedef enum logic [2:0] {
      I2C_IDLE,
      I2C_ADDR,
      I2C_ADDR_ACK,
      I2C_WDATA,
      I2C_WACK,
      I2C_RDATA,
      I2C_RACK
   } hsm_i2c_e;

   typedef struct packed {
      logic [6:0][7:0] bytes;
   } hsm_meas_s;

   typedef struct packed {
      logic out;
      logic oe;
   } hsm_drv_s;
endpackage

// ### core/hsm_pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module hsm_pin_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // pin and filtered level
   input  wire logic pin,
   output logic      level
);
   typedef struct packed {
      logic f1;
      logic f2;
      logic f3;
      logic lvl;
   } hsm_sync_s;

   hsm_sync_s s_q;
   hsm_sync_s s_d;

   always_comb begin
      s_d    = s_q;
      s_d.f1 = pin;
      s_d.f2 = s_q.f1;
      s_d.f3 = s_q.f2;
      // change accepted only once stages two and three agree
      if (s_q.f2 == s_q.f3) begin
         s_d.lvl = s_q.f3;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign level = s_q.lvl;
endmodule

// ### core/hsm_sensor_ctrl.sv
// measurement mode sequencing and serial register access of the field sensor
`timescale 1ns/1ps
module hsm_sensor_ctrl #(
   parameter logic [hsm_pkg::CNT_W-1:0] CAPTURE_CYC = hsm_pkg::CNT_W'(hsm_pkg::ADDR_CAPTURE_CYC),
   parameter logic [hsm_pkg::CNT_W-1:0] ULP_CYC     = hsm_pkg::CNT_W'(hsm_pkg::ULP_PERIOD_CYC),
   parameter logic [hsm_pkg::CNT_W-1:0] LOWP_CYC    = hsm_pkg::CNT_W'(hsm_pkg::LOWP_PERIOD_CYC)
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          reset_n,
   // serial bus pins
   input  wire logic          scl_in,
   input  wire logic          sda_in,
   output logic               sda_out,
   output logic               sda_oe,
   // converter
   output logic               conv_start,
   input  wire logic          conv_done,
   input  hsm_pkg::hsm_meas_s conv_result,
   // status
   output logic               int_n,
   output hsm_pkg::hsm_mode_e mode,
   output logic [6:0]         slave_addr,
   output logic               addr_fixed
);
   typedef struct packed {
      hsm_pkg::hsm_i2c_e    st;
      logic                 scl_p;
      logic                 sda_p;
      logic [3:0]           bit_cnt;
      logic [7:0]           shift;
      logic                 rw;
      logic [3:0]           rptr;
      logic [3:0]           wptr;
      logic                 oe;
      logic                 rd_txn;
      logic                 mt_set;
      logic                 wake_hit;
      logic                 skip;
      logic                 consist;
      logic                 busy_at_rd;
      logic [15:0][7:0]     wreg;
      hsm_pkg::hsm_meas_s   meas;
      logic                 cap_done;
      logic                 strap;
      logic [hsm_pkg::CNT_W-1:0] cap_cnt;
      logic [hsm_pkg::CNT_W-1:0] tmr;
      logic                 busy;
      logic                 start;
      logic                 mt_prev;
      logic                 mt_pend;
      logic [7:0]           int_cnt;
      logic                 int_n;
   } hsm_state_s;

   hsm_state_s s_q;
   hsm_state_s s_d;
   logic       scl_s;
   logic       sda_s;

   hsm_pin_sync #(.RESET_VAL(1'b1)) u_scl_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pin      (scl_in),
      .level    (scl_s)
   );

   hsm_pin_sync #(.RESET_VAL(1'b1)) u_sda_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pin      (sda_in),
      .level    (sda_s)
   );

   function automatic hsm_pkg::hsm_mode_e decode_mode(input logic [7:0] cfg1,
                                                      input logic [7:0] cfg3);
      logic fast;
      logic low;
      fast = cfg1[hsm_pkg::CFG1_FAST_BIT];
      low  = cfg1[hsm_pkg::CFG1_LOW_BIT];
      if (fast && low) begin
         decode_mode = hsm_pkg::MODE_MASTER_TRIGGERED;
      end else if (fast) begin
         decode_mode = hsm_pkg::MODE_CONTINUOUS;
      end else if (low && cfg3[hsm_pkg::CFG3_PERIOD_BIT]) begin
         decode_mode = hsm_pkg::MODE_LOW_POWER;
      end else if (low) begin
         decode_mode = hsm_pkg::MODE_ULTRA_LOW_POWER;
      end else begin
         decode_mode = hsm_pkg::MODE_POWER_DOWN;
      end
   endfunction

   function automatic logic [6:0] addr_of(input logic [1:0] sel);
      unique case (sel)
         2'h3: addr_of = hsm_pkg::ADDR_SEL_11;
         2'h2: addr_of = hsm_pkg::ADDR_SEL_10;
         2'h1: addr_of = hsm_pkg::ADDR_SEL_01;
         2'h0: addr_of = hsm_pkg::ADDR_SEL_00;
      endcase
   endfunction

   hsm_pkg::hsm_mode_e mode_c;
   logic [1:0]         asel_c;
   logic [6:0]         addr_c;
   logic [7:0]         cfg1_c;

   assign cfg1_c = s_q.wreg[hsm_pkg::WREG_CFG1];
   assign mode_c = decode_mode(cfg1_c, s_q.wreg[hsm_pkg::WREG_CFG3]);
   // low strap flips the upper select bit; high strap keeps the written value
   assign asel_c = cfg1_c[hsm_pkg::CFG1_ASEL_LSB +: 2] ^ {~s_q.strap, 1'b0};
   assign addr_c = addr_of(asel_c);

   // read side: 0-6 from the converter, 7-F mirror the shared write registers
   function automatic logic [7:0] rd_byte(input hsm_state_s s, input logic [3:0] idx);
      if (idx == hsm_pkg::RD_FLAG_IDX) begin
         rd_byte = s.meas.bytes[idx[2:0]];
         rd_byte[hsm_pkg::FLAG_CONSIST_BIT] = s.consist;
         rd_byte[hsm_pkg::FLAG_IDLE_BIT]    = ~s.busy_at_rd;
      end else if (idx <= hsm_pkg::RD_LAST_RO) begin
         rd_byte = s.meas.bytes[idx[2:0]];
      end else begin
         rd_byte = s.wreg[idx];
      end
   endfunction

   always_comb begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      logic read_done;
      logic pend;
      logic skip_set;
      logic [7:0] byte_c;
      logic [hsm_pkg::CNT_W-1:0] period;
      scl_rise  = 1'b0;
      scl_fall  = 1'b0;
      start_c   = 1'b0;
      stop_c    = 1'b0;
      read_done = 1'b0;
      pend      = 1'b0;
      skip_set  = 1'b0;
      byte_c    = 8'h00;
      period    = ULP_CYC;
      s_d       = s_q;
      s_d.start = 1'b0;
      s_d.scl_p = scl_s;
      s_d.sda_p = sda_s;
      scl_rise  = scl_s & ~s_q.scl_p;
      scl_fall  = ~scl_s & s_q.scl_p;
      start_c   = s_q.scl_p & scl_s & s_q.sda_p & ~sda_s;
      stop_c    = s_q.scl_p & scl_s & ~s_q.sda_p & sda_s;

      // address strap window after reset
      if (!s_q.cap_done) begin
         if (s_q.cap_cnt == CAPTURE_CYC - 1'b1) begin
            s_d.cap_done = 1'b1;
            s_d.strap    = sda_s;
         end else begin
            s_d.cap_cnt = s_q.cap_cnt + 1'b1;
         end
      end

      // serial slave
      if (!s_q.cap_done) begin
         s_d.st = hsm_pkg::I2C_IDLE;
      end else if (start_c || stop_c) begin
         read_done = s_q.rd_txn;
         skip_set  = s_q.mt_set && s_q.wake_hit
                     && s_q.wreg[hsm_pkg::WREG_CFG3][hsm_pkg::CFG3_CHECK_BIT];
         if (skip_set) begin
            s_d.skip = 1'b1;
         end
         s_d.st      = start_c ? hsm_pkg::I2C_ADDR : hsm_pkg::I2C_IDLE;
         s_d.bit_cnt = 4'h0;
         s_d.rptr    = 4'h0;
         s_d.wptr    = 4'h0;
         s_d.oe      = 1'b0;
         s_d.rd_txn  = 1'b0;
         s_d.mt_set  = 1'b0;
         s_d.wake_hit = 1'b0;
      end else begin
         unique case (s_q.st)
            hsm_pkg::I2C_IDLE: begin
               s_d.oe = 1'b0;
            end
            hsm_pkg::I2C_ADDR: begin
               if (scl_rise) begin
                  s_d.shift   = {s_q.shift[6:0], sda_s};
                  s_d.bit_cnt = s_q.bit_cnt + 1'b1;
               end else if (scl_fall && s_q.bit_cnt == 4'h8) begin
                  if (s_q.shift[7:1] == addr_c) begin
                     s_d.st = hsm_pkg::I2C_ADDR_ACK;
                     s_d.oe = 1'b1;
                     s_d.rw = s_q.shift[0];
                  end else begin
                     s_d.st = hsm_pkg::I2C_IDLE;
                  end
               end
            end
            hsm_pkg::I2C_ADDR_ACK: begin
               if (scl_fall) begin
                  s_d.bit_cnt = 4'h0;
                  if (s_q.rw) begin
                     byte_c       = rd_byte(s_q, s_q.rptr);
                     s_d.shift    = byte_c;
                     s_d.oe       = ~byte_c[7];
                     s_d.st       = hsm_pkg::I2C_RDATA;
                     s_d.consist  = 1'b1;
                     s_d.busy_at_rd = s_q.busy;
                  end else begin
                     s_d.oe = 1'b0;
                     s_d.st = hsm_pkg::I2C_WDATA;
                  end
               end
            end
            hsm_pkg::I2C_WDATA: begin
               if (scl_rise) begin
                  s_d.shift   = {s_q.shift[6:0], sda_s};
                  s_d.bit_cnt = s_q.bit_cnt + 1'b1;
               end else if (scl_fall && s_q.bit_cnt == 4'h8) begin
                  // all sixteen write slots store; 0-6 are simply never read back
                  s_d.wreg[s_q.wptr] = s_q.shift;
                  if (s_q.wptr == hsm_pkg::WREG_CFG1 && s_q.shift[hsm_pkg::CFG1_FAST_BIT]
                      && s_q.shift[hsm_pkg::CFG1_LOW_BIT] && s_q.shift[hsm_pkg::CFG1_INT_BIT]) begin
                     s_d.mt_set = 1'b1;
                  end
                  if (s_q.mt_set && s_q.wptr >= hsm_pkg::WAKE_FIRST
                      && s_q.wptr <= hsm_pkg::WAKE_LAST) begin
                     s_d.wake_hit = 1'b1;
                  end
                  s_d.oe = 1'b1;
                  s_d.st = hsm_pkg::I2C_WACK;
               end
            end
            hsm_pkg::I2C_WACK: begin
               if (scl_fall) begin
                  s_d.oe      = 1'b0;
                  s_d.wptr    = s_q.wptr + 1'b1;
                  s_d.bit_cnt = 4'h0;
                  s_d.st      = hsm_pkg::I2C_WDATA;
               end
            end
            hsm_pkg::I2C_RDATA: begin
               if (scl_rise) begin
                  s_d.bit_cnt = s_q.bit_cnt + 1'b1;
               end else if (scl_fall) begin
                  if (s_q.bit_cnt == 4'h8) begin
                     s_d.oe = 1'b0;
                     s_d.st = hsm_pkg::I2C_RACK;
                  end else begin
                     s_d.oe = ~s_q.shift[3'h7 - s_q.bit_cnt[2:0]];
                  end
               end
            end
            hsm_pkg::I2C_RACK: begin
               if (scl_rise) begin
                  s_d.rd_txn = 1'b1;
                  if (sda_s) begin
                     s_d.st = hsm_pkg::I2C_IDLE; // nack: wait for stop
                  end
               end else if (scl_fall) begin
                  byte_c      = rd_byte(s_q, s_q.rptr + 1'b1);
                  s_d.rptr    = s_q.rptr + 1'b1;
                  s_d.shift   = byte_c;
                  s_d.oe      = ~byte_c[7];
                  s_d.bit_cnt = 4'h0;
                  s_d.st      = hsm_pkg::I2C_RDATA;
               end
            end
         endcase
      end

      // conversion sequencing
      s_d.mt_prev = (mode_c == hsm_pkg::MODE_MASTER_TRIGGERED);
      if (s_q.int_cnt != 8'h00) begin
         s_d.int_cnt = s_q.int_cnt - 1'b1;
      end
      if (s_q.busy && conv_done) begin
         s_d.busy = 1'b0;
         s_d.meas = conv_result;
         if (s_q.st == hsm_pkg::I2C_RDATA || s_q.st == hsm_pkg::I2C_RACK) begin
            s_d.consist = 1'b0;
         end
         if (cfg1_c[hsm_pkg::CFG1_INT_BIT]) begin
            if (s_q.skip) begin
               // a fresh arm in this same cycle outlives the consumed one
               s_d.skip = skip_set;
            end else begin
               s_d.int_cnt = 8'(hsm_pkg::INT_PULSE_CYC);
            end
         end
      end
      unique case (mode_c)
         hsm_pkg::MODE_POWER_DOWN: begin
            s_d.tmr = '0;
         end
         hsm_pkg::MODE_CONTINUOUS: begin
            s_d.tmr = '0;
            if (!s_q.busy) begin
               s_d.start = 1'b1;
            end
         end
         hsm_pkg::MODE_LOW_POWER,
         hsm_pkg::MODE_ULTRA_LOW_POWER: begin
            period = (mode_c == hsm_pkg::MODE_LOW_POWER) ? LOWP_CYC : ULP_CYC;
            // wake-up timer paces conversions; a late finish just waits for next tick
            if (s_q.tmr >= period - 1'b1) begin
               s_d.tmr   = '0;
               s_d.start = ~s_q.busy;
            end else begin
               s_d.tmr = s_q.tmr + 1'b1;
            end
         end
         hsm_pkg::MODE_MASTER_TRIGGERED: begin
            s_d.tmr = '0;
            pend    = s_q.mt_pend | ~s_q.mt_prev | read_done;
            if (pend && !s_q.busy) begin
               s_d.start = 1'b1;
            end
            s_d.mt_pend = pend & s_q.busy;
         end
      endcase
      if (mode_c != hsm_pkg::MODE_MASTER_TRIGGERED) begin
         s_d.mt_pend = 1'b0;
      end
      if (s_d.start) begin
         s_d.busy = 1'b1;
      end
      s_d.int_n = (s_d.int_cnt == 8'h00);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q            <= '0;
         s_q.st         <= hsm_pkg::I2C_IDLE;
         s_q.scl_p      <= 1'b1;
         s_q.sda_p      <= 1'b1;
         s_q.wreg       <= {16{hsm_pkg::WREG_RESET}};
         s_q.strap      <= 1'b1;
         s_q.consist    <= 1'b1;
         s_q.mt_prev    <= 1'b0;
         s_q.int_n      <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign sda_out    = 1'b0;
   assign sda_oe     = s_q.oe;
   assign conv_start = s_q.start;
   assign int_n      = s_q.int_n;
   assign mode       = mode_c;
   assign slave_addr = addr_c;
   assign addr_fixed = s_q.cap_done;
endmodule

// ### tb/hsm_sensor_ctrl_sva.sv
// concurrent checks on the ports of the sensor control block
`timescale 1ns/1ps
module hsm_sensor_ctrl_sva #(
   parameter logic [hsm_pkg::CNT_W-1:0] CAPTURE_CYC = 'd20
) (
   // clock and reset
   input wire logic          core_clk,
   input wire logic          reset_n,
   // serial pins
   input wire logic          scl_in,
   input wire logic          sda_in,
   input wire logic          sda_oe,
   // converter and status
   input wire logic          conv_start,
   input wire logic          conv_done,
   input wire logic          int_n,
   input hsm_pkg::hsm_mode_e mode,
   input wire logic [6:0]    slave_addr,
   input wire logic          addr_fixed
);
   logic [7:0]               low_cnt_q;
   logic                     busy_q;
   logic                     scl_q;
   logic                     sda_q;
   logic [4:0]               since_stop_q;
   logic [hsm_pkg::CNT_W-1:0] since_rst_q;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_q <= 8'h00;
         busy_q <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         since_stop_q <= 5'h1f;
         since_rst_q <= '0;
      end else begin
         low_cnt_q <= int_n ? 8'h00 : low_cnt_q + 8'h01;
         busy_q <= conv_start ? 1'b1 : (conv_done ? 1'b0 : busy_q);
         scl_q <= scl_in;
         sda_q <= sda_in;
         // raw stop: data rises while clock stays high
         if (scl_q && scl_in && !sda_q && sda_in) since_stop_q <= 5'h00;
         else if (since_stop_q != 5'h1f) since_stop_q <= since_stop_q + 5'h01;
         if (since_rst_q != '1) since_rst_q <= since_rst_q + 1'b1;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_int_pulse_width: assert property (
      $rose(int_n) |-> low_cnt_q == 8'(hsm_pkg::INT_PULSE_CYC)) else $error("int pulse width");
   a_int_after_done: assert property (
      $fell(int_n) |-> $past(conv_done)) else $error("int without finished conversion");
   a_start_one_cycle: assert property (
      conv_start |=> !conv_start) else $error("conversion start longer than a cycle");
   a_single_conv: assert property (
      busy_q |-> !conv_start) else $error("conversion started while one runs");
   a_pd_no_conv: assert property (
      mode == hsm_pkg::MODE_POWER_DOWN && $past(mode) == hsm_pkg::MODE_POWER_DOWN
      |-> !conv_start) else $error("conversion in power-down");
   a_bus_quiet_early: assert property (
      !addr_fixed |-> !sda_oe) else $error("bus driven during address capture");
   a_addr_held: assert property (
      addr_fixed |=> addr_fixed) else $error("address capture reopened");
   a_capture_time: assert property (
      $rose(addr_fixed) |-> since_rst_q >= CAPTURE_CYC - 1'b1 && since_rst_q <= CAPTURE_CYC + 2'd2)
      else $error("address capture length");
   a_addr_in_map: assert property (
      slave_addr inside {7'h4a, 7'h4e, 7'h5a, 7'h5e}) else $error("slave address off map");
   a_mt_after_read: assert property (
      conv_start && mode == hsm_pkg::MODE_MASTER_TRIGGERED
      && $past(mode, 3) == hsm_pkg::MODE_MASTER_TRIGGERED |-> since_stop_q <= 5'd20)
      else $error("triggered conversion without read-out");
endmodule

bind hsm_sensor_ctrl hsm_sensor_ctrl_sva #(.CAPTURE_CYC(CAPTURE_CYC)) i_hsm_sensor_ctrl_sva (
   .core_clk(core_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
   .conv_start(conv_start), .conv_done(conv_done), .int_n(int_n), .mode(mode),
   .slave_addr(slave_addr), .addr_fixed(addr_fixed));

// ### tb/hsm_i2c_master.sv
// bit-level serial bus master standing in for the microcontroller
`timescale 1ns/1ps
module hsm_i2c_master (
   // clock
   input  wire logic core_clk,
   // bus lines
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low,
   // observed ack or read byte
   output logic      obs_valid,
   output logic [7:0] obs_val
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      obs_valid = 1'b0;
      obs_val = 8'h00;
   end

   // quarter bit of four cycles keeps each clock phase at eight cycles
   task automatic q(input int n);
      repeat (n * 4) @(posedge core_clk);
   endtask

   task automatic note(input logic [7:0] v);
      obs_val <= v;
      obs_valid <= 1'b1;
      @(posedge core_clk);
      obs_valid <= 1'b0;
   endtask

   task automatic start();
      sda_low <= 1'b0;
      scl <= 1'b1;
      q(1);
      sda_low <= 1'b1;
      q(2);
      scl <= 1'b0;
      q(1);
   endtask

   task automatic stop();
      sda_low <= 1'b1;
      q(1);
      scl <= 1'b1;
      q(2);
      sda_low <= 1'b0;
      q(2);
   endtask

   task automatic bit_x(input logic b, output logic s);
      sda_low <= ~b;
      q(1);
      scl <= 1'b1;
      q(1);
      #1 s = sda_line;
      q(1);
      scl <= 1'b0;
      q(1);
   endtask

   task automatic wr(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(b[i], s);
      bit_x(1'b1, s);
      ack = ~s;
      note({7'h00, ack});
   endtask

   // last byte answered with nack so the stop can follow
   task automatic rd(input logic last);
      logic [7:0] v;
      logic       s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         v[i] = s;
      end
      bit_x(last, s);
      note(v);
   endtask
endmodule

// ### tb/hsm_sensor_ctrl_tb_top.sv
// self-checking bench for the sensor control block
`timescale 1ns/1ps
`define HSM_CHECK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %h seen %h", nm, e, a); end end
module hsm_sensor_ctrl_tb_top;
   typedef struct {string nm; logic [7:0] v;} hsm_exp_s;
   logic core_clk, reset_n, scl, sda_low, sda_line, sda_out, sda_oe, conv_start, conv_done;
   logic int_n, addr_fixed, obs_valid, int_d;
   logic [7:0]         obs_val, r7;
   logic [6:0]         slave_addr, cur;
   hsm_pkg::hsm_meas_s conv_result;
   hsm_pkg::hsm_mode_e mode;
   hsm_exp_s           exp_q[$];
   hsm_exp_s           e;
   logic [71:0]        d;
   int miscompares = 0, comparisons = 0, cycles = 0, cwait = 0, conv_cnt = 0, int_cnt = 0;
   int c0, cb, i0, nc;
   logic [7:0]         row_cfg1[6] = '{8'h00, 8'h05, 8'h02, 8'h01, 8'h00, 8'h07};
   // last row also sets the consistency bit so the wake-up write arms the skip
   logic [7:0]         row_cfg3[6] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h80};
   int                 row_min[6] = '{0, 1, 1, 3, 0, 0};
   int                 row_max[6] = '{0, 3, 450, 5, 0, 0};
   hsm_pkg::hsm_mode_e row_mode[6] = '{hsm_pkg::MODE_POWER_DOWN, hsm_pkg::MODE_ULTRA_LOW_POWER,
      hsm_pkg::MODE_CONTINUOUS, hsm_pkg::MODE_LOW_POWER, hsm_pkg::MODE_POWER_DOWN,
      hsm_pkg::MODE_MASTER_TRIGGERED};
   logic [6:0]         addr_tab[4] = '{7'h5e, 7'h5a, 7'h4e, 7'h4a};

   // open-drain data line with pull-up
   assign sda_line = !sda_low && !(sda_oe && !sda_out);

   hsm_sensor_ctrl #(.CAPTURE_CYC(24'd20), .ULP_CYC(24'd200), .LOWP_CYC(24'd100))
      i_hsm_sensor_ctrl (
      .core_clk(core_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .conv_start(conv_start), .conv_done(conv_done),
      .conv_result(conv_result), .int_n(int_n), .mode(mode), .slave_addr(slave_addr),
      .addr_fixed(addr_fixed));
   hsm_i2c_master i_hsm_i2c_master (.core_clk(core_clk), .sda_line(sda_line), .scl(scl),
      .sda_low(sda_low), .obs_valid(obs_valid), .obs_val(obs_val));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // converter model with a random conversion time
   always @(posedge core_clk) begin
      conv_done <= 1'b0;
      if (conv_start) cwait <= 20 + $urandom_range(30);
      else if (cwait == 1) begin
         conv_done <= 1'b1;
         conv_result <= hsm_pkg::hsm_meas_s'(56'({$urandom, $urandom}));
         cwait <= 0;
      end else if (cwait > 1) cwait <= cwait - 1;
      if (conv_start) conv_cnt++;
      if (int_d && !int_n) int_cnt++;
      int_d = int_n;
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         wrap_up();
      end
   end

   always @(posedge core_clk) begin
      if (obs_valid) begin
         if (exp_q.size() == 0) `HSM_CHECK("unexpected result", 1'b0, 1'b1)
         else begin
            e = exp_q.pop_front();
            `HSM_CHECK(e.nm, e.v, obs_val)
         end
      end
   end

   task automatic expect_v(input string nm, input logic [7:0] v);
      exp_q.push_back(hsm_exp_s'{nm, v});
   endtask

   task automatic write_regs(input logic [6:0] a, input int n, input logic [63:0] w);
      logic k;
      i_hsm_i2c_master.start();
      expect_v("write address ack", 8'h01);
      i_hsm_i2c_master.wr({a, 1'b0}, k);
      for (int i = 0; i < n; i++) begin
         expect_v("write data ack", 8'h01);
         i_hsm_i2c_master.wr(w[63-8*i -: 8], k);
      end
      i_hsm_i2c_master.stop();
      repeat (8) @(posedge core_clk);
   endtask

   task automatic read_regs(input logic [6:0] a, input int n, input logic [71:0] x);
      logic k;
      i_hsm_i2c_master.start();
      expect_v("read address ack", 8'h01);
      i_hsm_i2c_master.wr({a, 1'b1}, k);
      for (int i = 0; i < n; i++) begin
         expect_v("read data", x[71-8*i -: 8]);
         i_hsm_i2c_master.rd(i == n - 1);
      end
      i_hsm_i2c_master.stop();
      repeat (8) @(posedge core_clk);
   endtask

   task automatic refused(input logic [6:0] a);
      logic k;
      i_hsm_i2c_master.start();
      expect_v("foreign address nack", 8'h00);
      i_hsm_i2c_master.wr({a, 1'b1}, k);
      i_hsm_i2c_master.stop();
   endtask

   task automatic wrap_up();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      reset_n = 1'b0;
      conv_done = 1'b0;
      conv_result = '0;
      int_d = 1'b1;
      void'($urandom(32'habeec556));
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      #1 `HSM_CHECK("mode after reset", hsm_pkg::MODE_POWER_DOWN, mode)
      `HSM_CHECK("address after reset", 7'h5e, slave_addr)
      `HSM_CHECK("capture still open", 1'b0, addr_fixed)
      repeat (30) @(posedge core_clk);
      #1 `HSM_CHECK("capture closed", 1'b1, addr_fixed)
      read_regs(7'h5e, 6, 72'h0);
      for (int r = 0; r < 6; r++) begin
         r7 = 8'($urandom);
         cb = conv_cnt;
         i0 = int_cnt;
         write_regs(7'h5e, 8, {8'h00, row_cfg1[r], 8'h00, row_cfg3[r], 24'h0, r7});
         `HSM_CHECK("mode", row_mode[r], mode)
         c0 = conv_cnt;
         repeat (450) @(posedge core_clk);
         nc = conv_cnt - c0;
         `HSM_CHECK("conversions in window", 1'b1, nc >= row_min[r] && nc <= row_max[r])
      end
      `HSM_CHECK("entry conversions", 1'b1, conv_cnt - cb == 1)
      `HSM_CHECK("entry int pulses", 1'b1, int_cnt - i0 == 1)
      for (int i = 0; i < 6; i++) d[71-8*i -: 8] = conv_result.bytes[i];
      d[23:0] = {conv_result.bytes[6][7:2], 2'b11, r7, 8'h00};
      c0 = conv_cnt;
      i0 = int_cnt;
      read_regs(7'h5e, 8, d);
      repeat (450) @(posedge core_clk);
      `HSM_CHECK("read-out conversions", 1'b1, conv_cnt - c0 == 1)
      `HSM_CHECK("skipped int pulses", 1'b1, int_cnt - i0 == 0)
      i0 = int_cnt;
      read_regs(7'h5e, 1, {conv_result.bytes[0], 64'h0});
      repeat (450) @(posedge core_clk);
      `HSM_CHECK("read-out int pulses", 1'b1, int_cnt - i0 == 1)
      cur = 7'h5e;
      for (int s = 3; s >= 0; s--) begin
         write_regs(cur, 2, {8'h00, 1'b0, 2'(s), 5'h00, 48'h0});
         `HSM_CHECK("slave address", addr_tab[s], slave_addr)
         refused(cur);
         cur = addr_tab[s];
         read_regs(cur, 1, {conv_result.bytes[0], 64'h0});
      end
      `HSM_CHECK("pending notes", 1'b1, exp_q.size() == 0)
      wrap_up();
   end
endmodule
